// *** rtl/epw_pwm_consts.vh ***
// Constants of the eight-channel PWM unit: register addresses, reset values, widths.
// Assumes the includer is plain Verilog with an 8-bit special function register address.
`ifndef EPW_PWM_CONSTS_VH
`define EPW_PWM_CONSTS_VH
`define EPW_ADDR_COMPARE_CH0 8'hF1
`define EPW_ADDR_COMPARE_CH5 8'hF6
`define EPW_ADDR_COUNTER_LOW 8'hF7
`define EPW_ADDR_ENABLE_MASK 8'hF8
`define EPW_ADDR_COUNTER_HIGH 8'hF9
`define EPW_ADDR_STRETCH_CH6 8'hFA
`define EPW_ADDR_COMPARE_CH6 8'hFB
`define EPW_ADDR_STRETCH_CH7 8'hFC
`define EPW_ADDR_COMPARE_CH7 8'hFD
`define EPW_RESET_REG 8'h00
`define EPW_COUNTER_WIDTH 14
`define EPW_NARROW_CHANNELS 6
`define EPW_MAX_DIV_CODE 3'h7
`endif

// *** rtl/epw_pwm_unit.v ***
// Eight-channel PWM unit with SFR-style register port and port-1 alternate outputs.
// Assumes single-cycle SFR read/write strobes synchronous to ref_clk and a
// clock-divide code supplied by the system clock control outside this block.
`include "epw_pwm_consts.vh"

// Overview of operation
// - Six 8-bit, two 14-bit individually enabled channels
// - 6-bit counter sets 8-bit base cycle
// - High at overflow unless zero; low on match
// - Low compare bits stretch cycles 1,3 / 2
// - 8-bit counter compared for 14-bit channels
// - Extension bits stretch chosen of 64 cycles
// - Outputs are alternate functions of port one
// - 14-bit value: compare plus six-bit extension
// - Compare registers double buffered, load at overflow
// - Counter bytes readable; writes are ignored
// - Unused compare registers act as storage
// - Counter runs while any enable set
// - Enable bit selects PWM or port pin
// - Stretch adds exactly one internal clock
// - High byte returns counter bits 13..8
// - All-ones compare gives 255 clocks high
module epw_pwm_unit #(
	parameter DIV_CODE_WIDTH = 3
) (
	// Clock and reset
	input  wire                      ref_clk,
	input  wire                      rst_b,
	// Special function register port
	input  wire [7:0]                sfrAddr,
	input  wire                      sfrWrite,
	input  wire                      sfrRead,
	input  wire [7:0]                sfrWriteData,
	output reg  [7:0]                sfrReadData,
	output wire                      sfrHit,
	// Clock divide code from system control
	input  wire [DIV_CODE_WIDTH-1:0] clockDivideCode,
	// Port one lines: port latch value and port-mode drive
	input  wire [7:0]                portLatch,
	output wire [7:0]                portOneLineOut,
	output wire [7:0]                portOneLineOe,
	output wire [7:0]                pwmActive
);

	// Shadow (written) and active compare values
	reg [7:0]  shadowCompare [0:7];
	reg [7:0]  activeCompare [0:7];
	reg [7:0]  shadowExt6;
	reg [7:0]  shadowExt7;
	reg [7:0]  activeExt6;
	reg [7:0]  activeExt7;
	reg [7:0]  channelEnableMask;
	reg [13:0] pwmCounter;
	reg [15:0] prescaler;
	reg [7:0]  pwmOut;
	reg [7:0]  next_pwmOut;
	wire       counterRunning;
	wire       internalTick;
	wire       narrowOverflow;
	wire       wideOverflow;
	wire [15:0] divideMask;
	integer    i;

	// Stretch decision for 8-bit channel; cycle index is counter bits 7:6
	function narrowStretch;
		input [1:0] lowBits;
		input [1:0] cycleIndex;
		begin
			narrowStretch = (lowBits[1] & cycleIndex[0]) |
				(lowBits[0] & (cycleIndex == 2'h2));
		end
	endfunction

	// Stretch decision for 14-bit channel; cycle index is counter bits 13:8
	function wideStretch;
		input [7:0] extBits;
		input [5:0] cycleIndex;
		begin
			wideStretch = (extBits[7] & cycleIndex[0]) |
				(extBits[6] & (cycleIndex[1:0] == 2'h2)) |
				(extBits[5] & (cycleIndex[2:0] == 3'h4)) |
				(extBits[4] & (cycleIndex[3:0] == 4'h8)) |
				(extBits[3] & (cycleIndex[4:0] == 5'h10)) |
				(extBits[2] & (cycleIndex == 6'h20));
		end
	endfunction

	// True for the six 8-bit compare addresses
	function narrowHit;
		input [7:0] addr;
		begin
			narrowHit = (addr >= `EPW_ADDR_COMPARE_CH0) && (addr <= `EPW_ADDR_COMPARE_CH5);
		end
	endfunction

	// Array slot of an 8-bit compare address; only valid when narrowHit holds
	function [2:0] narrowSlot;
		input [7:0] addr;
		begin
			narrowSlot = addr[2:0] - 3'h1;
		end
	endfunction

	// Active extension of one 14-bit channel
	function [7:0] wideExt;
		input       upper;
		input [7:0] ext6;
		input [7:0] ext7;
		begin
			wideExt = upper ? ext7 : ext6;
		end
	endfunction

	assign counterRunning = |channelEnableMask;

	// Divide by two to the code
	assign divideMask = (16'h0001 << clockDivideCode) - 16'h0001;
	assign internalTick = counterRunning && ((prescaler & divideMask) == divideMask);

	assign narrowOverflow = internalTick && (pwmCounter[5:0] == 6'h3F);
	assign wideOverflow = internalTick && (pwmCounter[7:0] == 8'hFF);

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			prescaler <= 16'h0000;
			pwmCounter <= 14'h0000;
		end else if (!counterRunning) begin
			prescaler <= 16'h0000;
			pwmCounter <= 14'h0000;
		end else begin
			prescaler <= prescaler + 16'h0001;
			if (internalTick) begin
				pwmCounter <= pwmCounter + 14'h0001;
			end
		end
	end

	// Register writes; counter bytes have no write path
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			channelEnableMask <= `EPW_RESET_REG;
			shadowExt6 <= `EPW_RESET_REG;
			shadowExt7 <= `EPW_RESET_REG;
			for (i = 0; i < 8; i = i + 1) begin
				shadowCompare[i] <= `EPW_RESET_REG;
			end
		end else if (sfrWrite) begin
			if (narrowHit(sfrAddr)) begin
				shadowCompare[narrowSlot(sfrAddr)] <= sfrWriteData;
			end
			case (sfrAddr)
				`EPW_ADDR_ENABLE_MASK: channelEnableMask <= sfrWriteData;
				`EPW_ADDR_COMPARE_CH6: shadowCompare[6] <= sfrWriteData;
				`EPW_ADDR_COMPARE_CH7: shadowCompare[7] <= sfrWriteData;
				// Low bits kept as written; software keeps them zero
				`EPW_ADDR_STRETCH_CH6: shadowExt6 <= sfrWriteData;
				`EPW_ADDR_STRETCH_CH7: shadowExt7 <= sfrWriteData;
				default: ;
			endcase
		end
	end

	// Active copies follow shadows at overflow or while stopped
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			activeExt6 <= `EPW_RESET_REG;
			activeExt7 <= `EPW_RESET_REG;
			for (i = 0; i < 8; i = i + 1) begin
				activeCompare[i] <= `EPW_RESET_REG;
			end
		end else begin
			for (i = 0; i < `EPW_NARROW_CHANNELS; i = i + 1) begin
				if (!counterRunning || narrowOverflow) begin
					activeCompare[i] <= shadowCompare[i];
				end
			end
			// Wide value is compare plus extension
			if (!counterRunning || wideOverflow) begin
				activeCompare[6] <= shadowCompare[6];
				activeCompare[7] <= shadowCompare[7];
				activeExt6 <= shadowExt6;
				activeExt7 <= shadowExt7;
			end
		end
	end

	// Output levels. The level is updated on each tick and shows the count just
	// reached, so an overflow raises the line and a match drops it; a stretched
	// cycle holds the line one tick longer.
	always @* begin
		for (i = 0; i < 8; i = i + 1) begin
			next_pwmOut[i] = pwmOut[i];
		end
		if (internalTick) begin
			for (i = 0; i < `EPW_NARROW_CHANNELS; i = i + 1) begin
				// Set at overflow, clear on match
				if (narrowOverflow) begin
					next_pwmOut[i] = (activeCompare[i][7:2] != 6'h00) ||
						narrowStretch(activeCompare[i][1:0], pwmCounter[7:6] + 2'h1);
				end else if ({2'h0, activeCompare[i][7:2]} == {2'h0, pwmCounter[5:0] + 6'h01}) begin
					next_pwmOut[i] = narrowStretch(activeCompare[i][1:0], pwmCounter[7:6]);
				end else if ({2'h0, activeCompare[i][7:2]} == {2'h0, pwmCounter[5:0]}) begin
					next_pwmOut[i] = 1'b0;
				end
			end
			for (i = 6; i < 8; i = i + 1) begin
				if (wideOverflow) begin
					next_pwmOut[i] = (activeCompare[i] != 8'h00) ||
						wideStretch(wideExt(i == 7, activeExt6, activeExt7),
							pwmCounter[13:8] + 6'h01);
				end else if (activeCompare[i] == pwmCounter[7:0] + 8'h01) begin
					next_pwmOut[i] = wideStretch(wideExt(i == 7, activeExt6, activeExt7),
						pwmCounter[13:8]);
				end else if (activeCompare[i] == pwmCounter[7:0]) begin
					next_pwmOut[i] = 1'b0;
				end
			end
		end
		if (!counterRunning) begin
			next_pwmOut = 8'h00;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			pwmOut <= 8'h00;
		end else begin
			pwmOut <= next_pwmOut & channelEnableMask;
		end
	end

	// Alternate function mux on port one
	assign pwmActive = channelEnableMask;
	assign portOneLineOut = (channelEnableMask & pwmOut) | (~channelEnableMask & portLatch);
	// Port mode is quasi-bidirectional: drive only a low; PWM drives both levels
	assign portOneLineOe = channelEnableMask | ~portLatch;

	assign sfrHit = (sfrAddr >= `EPW_ADDR_COMPARE_CH0) && (sfrAddr <= `EPW_ADDR_COMPARE_CH7);

	// Registered read data
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			sfrReadData <= 8'h00;
		end else if (sfrRead) begin
			if (narrowHit(sfrAddr)) begin
				sfrReadData <= shadowCompare[narrowSlot(sfrAddr)];
			end else begin
				case (sfrAddr)
					`EPW_ADDR_COUNTER_LOW: sfrReadData <= pwmCounter[7:0];
					`EPW_ADDR_ENABLE_MASK: sfrReadData <= channelEnableMask;
					`EPW_ADDR_COUNTER_HIGH: sfrReadData <= {2'h0, pwmCounter[13:8]};
					`EPW_ADDR_STRETCH_CH6: sfrReadData <= shadowExt6;
					`EPW_ADDR_COMPARE_CH6: sfrReadData <= shadowCompare[6];
					`EPW_ADDR_STRETCH_CH7: sfrReadData <= shadowExt7;
					`EPW_ADDR_COMPARE_CH7: sfrReadData <= shadowCompare[7];
					default: sfrReadData <= 8'h00;
				endcase
			end
		end
	end

endmodule

// *** verif/epw_pwm_unit_props.sv ***
// Port-level checker for the eight-channel PWM unit.
// Assumes it is bound to epw_pwm_unit and sees only that module's ports.
module epw_pwm_props #(
	parameter DIV_CODE_WIDTH = 3
) (
	// Clock and reset
	input wire logic                      ref_clk,
	input wire logic                      rst_b,
	// Register port
	input wire logic [7:0]                sfrAddr,
	input wire logic                      sfrWrite,
	input wire logic                      sfrRead,
	input wire logic [7:0]                sfrWriteData,
	input wire logic [7:0]                sfrReadData,
	input wire logic                      sfrHit,
	// Divide code and port one
	input wire logic [DIV_CODE_WIDTH-1:0] clockDivideCode,
	input wire logic [7:0]                portLatch,
	input wire logic [7:0]                portOneLineOut,
	input wire logic [7:0]                portOneLineOe,
	input wire logic [7:0]                pwmActive
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_hit_range: assert property (sfrHit == (sfrAddr >= 8'hF1 && sfrAddr <= 8'hFD))
		else $error("hit range wrong");
	a_mask_mirror: assert property (sfrWrite && sfrAddr == 8'hF8 |=>
		pwmActive == $past(sfrWriteData)) else $error("mask not taken");
	a_mask_read: assert property (sfrRead && !sfrWrite && sfrAddr == 8'hF8 |=>
		sfrReadData == pwmActive) else $error("mask readback wrong");
	a_unmapped_zero: assert property (sfrRead && !sfrHit |=> sfrReadData == 8'h00)
		else $error("unmapped read not zero");
	a_read_holds: assert property (!sfrRead |=> $stable(sfrReadData))
		else $error("read data moved");
	a_port_pass: assert property (((portOneLineOut ^ portLatch) & ~pwmActive) == 8'h00)
		else $error("port line not passed");
	a_oe_mux: assert property (portOneLineOe == (pwmActive | ~portLatch))
		else $error("enable mux wrong");
	a_stopped_count: assert property (pwmActive == 8'h00 && $past(pwmActive) == 8'h00
		&& sfrRead && sfrAddr == 8'hF7 |=> sfrReadData == 8'h00) else $error("counter ran");
	a_high_top: assert property (sfrRead && sfrAddr == 8'hF9 |=> sfrReadData[7:6] == 2'b00)
		else $error("high byte top bits");
endmodule

bind epw_pwm_unit epw_pwm_props #(.DIV_CODE_WIDTH(DIV_CODE_WIDTH)) uProps (
	.ref_clk(ref_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
	.sfrRead(sfrRead), .sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData),
	.sfrHit(sfrHit), .clockDivideCode(clockDivideCode), .portLatch(portLatch),
	.portOneLineOut(portOneLineOut), .portOneLineOe(portOneLineOe), .pwmActive(pwmActive));

// *** verif/epw_pwm_unit_tb.sv ***
// Self-checking bench for the PWM unit: registers, pin muxing, duty counts.
// Counts high clocks over whole stretch periods after a warm-up, so phase does not matter.
module epw_pwm_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, rst_b, sfrWrite, sfrRead, sfrHit;
	logic [7:0]  sfrAddr, sfrWriteData, sfrReadData, portLatch, pinOut, pinOe, active;
	logic [2:0]  divCode;
	logic [15:0] high0, high6;
	int          err_total = 0;
	int          tests_run = 0;
	epw_pwm_unit uut (.ref_clk(ref_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
		.sfrRead(sfrRead), .sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData),
		.sfrHit(sfrHit), .clockDivideCode(divCode), .portLatch(portLatch),
		.portOneLineOut(pinOut), .portOneLineOe(pinOe), .pwmActive(active));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfrAddr <= a;
		sfrWriteData <= d;
		sfrWrite <= 1'b1;
		@(posedge ref_clk);
		sfrWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		sfrAddr <= a;
		sfrRead <= 1'b1;
		@(posedge ref_clk);
		sfrRead <= 1'b0;
		#1 chk("read data", {8'h00, sfrReadData}, {8'h00, exp});
	endtask
	// High clocks of lines 0 and 6 over n cycles
	task automatic measure(input int n);
		high0 = 16'h0000;
		high6 = 16'h0000;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			high0 += {15'h0000, pinOut[0]};
			high6 += {15'h0000, pinOut[6]};
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		sfrWrite = 1'b0;
		sfrRead = 1'b0;
		sfrAddr = 8'h00;
		sfrWriteData = 8'h00;
		divCode = 3'h0;
		portLatch = 8'hA5;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(8'hFB, 8'h00);
		// Unmapped and counter bytes must ignore the writes
		for (int a = 'hF0; a <= 'hFE; a++)
			if (a != 'hF8)
				wr(8'(a), 8'(a << 2));
		for (int a = 'hF0; a <= 'hFE; a++)
			rd(8'(a), (a inside {'hF0, 'hF7, 'hF8, 'hF9, 'hFE}) ? 8'h00 : 8'(a << 2));
		$display("test registers done");
		// Stopped counter: compare values load at once
		wr(8'hF1, 8'h08);
		wr(8'hFB, 8'h03);
		wr(8'hFA, 8'h84);
		wr(8'hF8, 8'h41);
		// First pulses only start at the first overflow, so skip one wide base cycle
		measure(256);
		measure(16384);
		chk("ch0 high", high0, 16'd512);
		chk("ch6 high", high6, 16'd225);
		chk("port out", {8'h00, pinOut & 8'hBE}, 16'h00A4);
		chk("pin oe", {8'h00, pinOe}, 16'h005B);
		wr(8'hF1, 8'h0B);
		measure(256);
		measure(16384);
		chk("ch0 stretched", high0, 16'd704);
		divCode <= 3'h1;
		measure(1024);
		measure(16384);
		chk("ch0 divided", high0, 16'd704);
		wr(8'hFA, 8'h00);
		wr(8'hFB, 8'hFF);
		measure(1024);
		measure(16384);
		chk("ch6 full", high6, 16'd16320);
		$display("test duty done");
		wr(8'hF8, 8'h00);
		rd(8'hF7, 8'h00);
		rd(8'hF1, 8'h0B);
		chk("port idle", {8'h00, pinOut}, 16'h00A5);
		$display("test stop done");
		close_out();
	end
endmodule
